// ---- pkg/gtps_pkg.sv ----
// Purpose: Shared constants for the gear-tooth peak/valley switch core
// Assumes: 20 MHz system clock, 500 kHz internal sampling rate
// Notes:   Hysteresis code is a 6-bit value in converter units
package gtps_pkg;
  localparam int          GTPS_ADC_W        = 12;
  localparam int          GTPS_HYS_W        = 6;
  localparam int          GTPS_CLK_HZ       = 20000000;
  localparam int          GTPS_SAMPLE_HZ    = 500000;
  localparam int          GTPS_SAMPLE_DIV   = GTPS_CLK_HZ / GTPS_SAMPLE_HZ;
  localparam int          GTPS_DIV_W        = 6;
  localparam logic [5:0]  GTPS_HYS_DEFAULT  = 6'h10;
  localparam logic        GTPS_OUT_RESET    = 1'b1;
  typedef enum logic [1:0] {GTPS_ST_WAIT_FIRST, GTPS_ST_TRACK_MIN, GTPS_ST_TRACK_MAX} gtps_state_t;
endpackage : gtps_pkg

// ---- hdl/gtps_sample_tick.sv ----
// Purpose: Divider giving a one-cycle sampling enable
// Assumes: Single clock domain
// Notes:   Pulse every DIV cycles
`timescale 1ns/10ps
module gtps_sample_tick
  import gtps_pkg::*;
#(
  parameter int DIV = GTPS_SAMPLE_DIV
)(
  input  wire logic clock,
  input  wire logic reset,
  output logic      tick
);
  logic [GTPS_DIV_W-1:0] cnt_r;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (cnt_r == GTPS_DIV_W'(DIV - 1))
    begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule : gtps_sample_tick

// ---- hdl/gtps_core.sv ----
// Purpose: Peak/valley tracking switch core of a gear-tooth sensor
// Assumes: adc_sample comes from converter logic on the same clock
// Assumes: hys_code is a static strap from outside this clock domain
// Notes:   high_current_output_level=1 means high supply current
// Notes:   Current pins follow a captured sample after two clocks
// Notes:   hys_code is taken only until the first sample after reset
// Notes:   Until first_min_found rises the level carries no field data
`timescale 1ns/10ps
module gtps_core
  import gtps_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic [GTPS_ADC_W-1:0] adc_sample,
  input  wire logic [GTPS_HYS_W-1:0] hys_code,
  output logic                       high_current_output_level,
  output logic                       low_current_output_level,
  output logic                       sample_strobe,
  output logic                       first_min_found
);
  logic                  tick;
  logic [GTPS_ADC_W-1:0] hold_r;
  logic                  hold_vld_r;
  logic [GTPS_HYS_W-1:0] hys_r;
  // Hysteresis strap synchroniser and its steadiness test
  logic [GTPS_HYS_W-1:0] hys_meta_r;
  logic [GTPS_HYS_W-1:0] hys_sync_r;
  logic [GTPS_HYS_W-1:0] hys_last_r;
  logic                  hys_steady;
  logic [GTPS_ADC_W:0]   ext_r;
  logic                  ext_vld_r;
  gtps_state_t           state_r;
  logic                  out_r;
  logic                  found_r;

  // Combinational distance terms
  logic [GTPS_ADC_W:0]   cur;
  logic [GTPS_ADC_W:0]   hys_x;
  logic                  fell;
  logic                  rose;

  // Sampling enable, one pulse per converter word
  gtps_sample_tick #(.DIV(GTPS_SAMPLE_DIV)) u_tick
  (
    .clock (clock),
    .reset (reset),
    .tick  (tick)
  );

  // Sample-and-hold of converter word
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      hold_r     <= '0;
      hold_vld_r <= 1'b0;
    end
    else if (tick)
    begin
      hold_r     <= adc_sample;
      hold_vld_r <= 1'b1;
    end
    else
    begin
      hold_vld_r <= 1'b0;
    end
  end

  // The strap word crosses into this clock through two flops
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      hys_meta_r <= GTPS_HYS_DEFAULT;
      hys_sync_r <= GTPS_HYS_DEFAULT;
    end
    else
    begin
      hys_meta_r <= hys_code;
      hys_sync_r <= hys_meta_r;
    end
  end

  // A word that held still for a clock is not a torn mix of two codes
  always_ff @(posedge clock)
  begin
    if (reset)
      hys_last_r <= GTPS_HYS_DEFAULT;
    else
      hys_last_r <= hys_sync_r;
  end

  assign hys_steady = (hys_sync_r == hys_last_r);

  // Hysteresis code only changes from reset release until the first sample, never from signal size
  always_ff @(posedge clock)
  begin
    if (reset)
      hys_r <= GTPS_HYS_DEFAULT;
    else if (!found_r && state_r == GTPS_ST_WAIT_FIRST && !ext_vld_r && hys_steady)
      hys_r <= hys_sync_r;
  end

  // Distances are one bit wider than a sample so they never wrap
  assign cur   = {1'b0, hold_r};
  assign hys_x = {{(GTPS_ADC_W + 1 - GTPS_HYS_W){1'b0}}, hys_r};
  assign fell  = (ext_r >= cur) && ((ext_r - cur) >= hys_x);
  assign rose  = (cur >= ext_r) && ((cur - ext_r) >= hys_x);

  // Extreme tracking: thresholds are relative, so any bias works
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ext_r     <= '0;
      ext_vld_r <= 1'b0;
      state_r   <= GTPS_ST_WAIT_FIRST;
    end
    else if (hold_vld_r)
    begin
      // First sample after reset only loads the reference
      if (!ext_vld_r)
      begin
        ext_r     <= cur;
        ext_vld_r <= 1'b1;
      end
      else
      begin
        case (state_r)
          // Valley search: follow the minimum, switch high on a rise
          GTPS_ST_WAIT_FIRST, GTPS_ST_TRACK_MIN:
          begin
            if (cur < ext_r)
              ext_r <= cur;
            else if (rose)
            begin
              ext_r   <= cur;
              state_r <= GTPS_ST_TRACK_MAX;
            end
          end
          // Peak search: follow the maximum, switch low on a fall
          GTPS_ST_TRACK_MAX:
          begin
            if (cur > ext_r)
              ext_r <= cur;
            else if (fell)
            begin
              ext_r   <= cur;
              state_r <= GTPS_ST_TRACK_MIN;
            end
          end
          // Unused code falls back to the valley search
          default:
            state_r <= GTPS_ST_WAIT_FIRST;
        endcase
      end
    end
  end

  // Output current level: one flop carries the switching decision
  always_ff @(posedge clock)
  begin
    if (reset)
      out_r <= GTPS_OUT_RESET;
    else if (hold_vld_r && ext_vld_r)
    begin
      if (state_r != GTPS_ST_TRACK_MAX && cur >= ext_r && rose)
        out_r <= 1'b1;
      else if (state_r == GTPS_ST_TRACK_MAX && cur <= ext_r && fell)
        out_r <= 1'b0;
    end
  end

  // First rise after a minimum arms the output until the next reset
  always_ff @(posedge clock)
  begin
    if (reset)
      found_r <= 1'b0;
    else if (hold_vld_r && ext_vld_r && state_r != GTPS_ST_TRACK_MAX && rose)
      found_r <= 1'b1;
  end

  // Complementary current-level pins, both straight from flops
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      high_current_output_level <= GTPS_OUT_RESET;
      low_current_output_level  <= ~GTPS_OUT_RESET;
    end
    else
    begin
      high_current_output_level <= out_r;
      low_current_output_level  <= ~out_r;
    end
  end

  // One-cycle marker that a held sample has been judged
  always_ff @(posedge clock)
  begin
    if (reset)
      sample_strobe <= 1'b0;
    else
      sample_strobe <= hold_vld_r;
  end

  // Tells the receiver when the level starts to carry field data
  always_ff @(posedge clock)
  begin
    if (reset)
      first_min_found <= 1'b0;
    else
      first_min_found <= found_r;
  end
endmodule : gtps_core

// ---- tb/gtps_core_assertions.sv ----
// Purpose: Output checks
// Assumes: One clock
// Notes: Bound in tb
`timescale 1ns/10ps
module gtps_core_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic high_current_output_level,
  input wire logic low_current_output_level,
  input wire logic sample_strobe,
  input wire logic first_min_found
);
  wire h = high_current_output_level;
  wire f = first_min_found;
  wire s = sample_strobe;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_out_compl: assert property (h != low_current_output_level) else $error("compl");
  a_reset_high: assert property (disable iff (1'b0) reset |=> h && !f) else $error("rst");
  a_no_early: assert property (!f |-> h) else $error("early");
  a_found_held: assert property (f |=> f) else $error("held");
  a_found_strobe: assert property ($rose(f) |-> $past(s)) else $error("fs");
  a_out_strobe: assert property ($changed(h) |-> $past(s)) else $error("os");
  a_strobe_gap: assert property (s |=> !s [*8]) else $error("gap");
  a_fall_armed: assert property ($fell(h) |-> f) else $error("fall");
endmodule : gtps_core_assertions

// ---- tb/gtps_ecu_model.sv ----
// Purpose: Control unit sensing supply current
// Assumes: Core clock
// Notes: Counts current drops as teeth
`timescale 1ns/10ps
module gtps_ecu_model (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic high_current_output_level,
  input  wire logic first_min_found,
  output int        teeth
);
  logic prev_r;
  always_ff @(posedge clock)
  begin
    prev_r <= high_current_output_level;
    if (reset)
      teeth <= 0;
    else if (first_min_found && prev_r && !high_current_output_level)
      teeth <= teeth + 1;
  end
endmodule : gtps_ecu_model

// ---- tb/tb_gtps_core.sv ----
// Purpose: Bench for gtps_core
// Assumes: Hysteresis code 8, then 0x20 after a mid-run reset
// Notes: Inputs move on falling edge
`timescale 1ns/10ps
module tb_gtps_core;
  logic        clock = 0;
  logic        reset = 1;
  logic [11:0] adc = 12'h800;
  logic [5:0]  hys = 6'h08;
  logic        hi, lo, stb, fmf;
  int          error_cnt = 0;
  int          checks = 0;
  int          teeth;
  always #25 clock = ~clock;
  gtps_core gtps_core_inst (.clock(clock), .reset(reset), .adc_sample(adc), .hys_code(hys),
    .high_current_output_level(hi), .low_current_output_level(lo), .sample_strobe(stb), .first_min_found(fmf));
  gtps_ecu_model gtps_ecu_model_inst (.clock(clock), .reset(reset), .high_current_output_level(hi),
    .first_min_found(fmf), .teeth(teeth));
  task chk(input logic [2:0] seen, input logic [2:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %b want %b", $time, seen, exp);
    end
  endtask : chk
  task feed(input logic [11:0] v, input logic [2:0] e);
    int n;
    n = 0;
    adc = v;
    @(negedge clock);
    while (stb !== 1'b1 && n < 90)
    begin
      @(negedge clock);
      n++;
    end
    chk({2'b00, stb}, 3'b001);
    @(negedge clock);
    chk({hi, lo, fmf}, e);
  endtask : feed
  task t_power_on;
    repeat (10) @(negedge clock);
    chk({hi, lo, fmf}, 3'b100);
    reset = 0;
    feed(12'h800, 3'b100);
    feed(12'h6f0, 3'b100);
    feed(12'h6f7, 3'b100);
    feed(12'h6f8, 3'b101);
    $display("power_on end");
  endtask : t_power_on
  task t_peak;
    feed(12'h780, 3'b101);
    feed(12'h779, 3'b101);
    feed(12'h778, 3'b011);
    feed(12'h77f, 3'b011);
    feed(12'h780, 3'b101);
    feed(12'hff0, 3'b101);
    feed(12'hfe8, 3'b011);
    @(negedge clock);
    chk({2'b00, teeth == 2}, 3'b001);
    $display("peak end");
  endtask : t_peak
  task t_mid_reset;
    hys = 6'h20;
    reset = 1;
    repeat (10) @(negedge clock);
    chk({hi, lo, fmf}, 3'b100);
    reset = 0;
    feed(12'h400, 3'b100);
    hys = 6'h01;
    feed(12'h300, 3'b100);
    feed(12'h31f, 3'b100);
    feed(12'h320, 3'b101);
    feed(12'h301, 3'b101);
    feed(12'h300, 3'b011);
    @(negedge clock);
    chk({2'b00, teeth == 1}, 3'b001);
    $display("mid_reset end");
  endtask : t_mid_reset
  task complete_run;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  initial
  begin
    t_power_on();
    t_peak();
    t_mid_reset();
    complete_run();
  end
  initial
  begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule : tb_gtps_core
bind gtps_core gtps_core_assertions gtps_core_assertions_inst (.clock(clock), .reset(reset),
  .high_current_output_level(high_current_output_level), .low_current_output_level(low_current_output_level),
  .sample_strobe(sample_strobe), .first_min_found(first_min_found));
